// File: logic/lifc_cfg.svh
/*
 Register map, field layout and reset values of the logical input force
 control bank. Assumes a holding-register access port that presents one
 16-bit word address per access, synchronous to the block clock.
*/
`ifndef LIFC_CFG_SVH
`define LIFC_CFG_SVH

`define LIFC_ADDR_EXECUTE    16'hA0D6
`define LIFC_ADDR_PASS_LEFT  16'hA0D7
`define LIFC_ADDR_PASS_RIGHT 16'hA0D8
`define LIFC_ADDR_SPARE      16'hA0D9
`define LIFC_ADDR_SEL_UPPER  16'hA0DA
`define LIFC_ADDR_SEL_LOWER  16'hA0DB
`define LIFC_ADDR_MODE_UPPER 16'hA0DC
`define LIFC_ADDR_MODE_LOWER 16'hA0DD
`define LIFC_ADDR_VAL_UPPER  16'hA0DE
`define LIFC_ADDR_VAL_LOWER  16'hA0DF

`define LIFC_EXEC_NONE       16'h0000
`define LIFC_EXEC_RUN        16'h0001
`define LIFC_WORD_RESET      16'h0000
`define LIFC_PASSWORD_LEFT   16'h4141
`define LIFC_PASSWORD_RIGHT  16'h4141

`endif

// File: logic/lifc_force_bank.sv
/*
 Holding-register bank that forces 32 logical inputs on or off.
 Assumes the host port presents one access per cycle at most; word
 addresses are the printed register numbers. Input 1 is bit 0 of the
 32-bit logic-point vectors.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lifc_cfg.svh"

module lifc_force_bank #(
    parameter int unsigned POINTS = 32
)
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // Host register port
    input  wire lifc_pkg::lifc_req_t i_req,
    output lifc_pkg::lifc_rsp_t    o_rsp,
    // Logical points
    input  wire logic [POINTS-1:0] i_point_normal,
    output logic [POINTS-1:0]      o_point_value,
    output logic [POINTS-1:0]      o_point_forced,
    output logic                   o_any_forced,
    output logic                   o_exec_rejected
);

    // Elaboration check: the map holds exactly two 16-bit halves
    if (POINTS != 32)
    begin
        $error("lifc_force_bank serves exactly 32 points");
    end

    // Control words
    logic [15:0]           exec_q;
    logic [15:0]           pass_left_q;
    logic [15:0]           pass_right_q;
    logic                  rejected_q;

    // Staged masks, one vector per kind, bit 0 is input 1
    logic [31:0]           select_q;
    logic [31:0]           mode_q;
    logic [31:0]           value_q;
    lifc_pkg::lifc_masks_t staged;
    // Masks in force
    lifc_pkg::lifc_masks_t active_q;

    // Decode terms
    logic                  access;
    logic                  mapped;
    logic                  exec_hit;
    logic                  pass_ok;
    logic [15:0]           rdata_d;

    // True when the word address falls inside the bank, spare included
    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a >= `LIFC_ADDR_EXECUTE) && (a <= `LIFC_ADDR_VAL_LOWER);
    endfunction

    // A write strobe aimed at one word of the bank
    function automatic logic write_to(
        input lifc_pkg::lifc_req_t r,
        input logic [15:0]         a
    );
        write_to = r.wr && (r.addr == a);
    endfunction

    // Truth table: forced only when selected and in force mode
    function automatic logic [31:0] force_mask(input lifc_pkg::lifc_masks_t m);
        force_mask = m.select & m.mode;
    endfunction

    // Forced points take their state bit, the rest pass the normal input
    function automatic logic [31:0] point_result(
        input lifc_pkg::lifc_masks_t m,
        input logic [31:0]           normal
    );
        point_result = (force_mask(m) & m.value)
                     | (~force_mask(m) & normal);
    endfunction

    // Upper half of a 32-bit mask is the word for inputs 17-32
    function automatic logic [15:0] upper_word(input logic [31:0] v);
        upper_word = v[31:16];
    endfunction

    // Lower half of a 32-bit mask is the word for inputs 1-16
    function automatic logic [15:0] lower_word(input logic [31:0] v);
        lower_word = v[15:0];
    endfunction

    assign access   = i_req.wr || i_req.rd;
    assign mapped   = is_mapped(i_req.addr);
    assign staged   = '{select: select_q, mode: mode_q, value: value_q};
    // Both password words are compared at the execute edge
    assign pass_ok  = (pass_left_q == `LIFC_PASSWORD_LEFT)
                   && (pass_right_q == `LIFC_PASSWORD_RIGHT);
    // Execute only acts on a write of exactly 1; any other value is inert
    assign exec_hit = write_to(i_req, `LIFC_ADDR_EXECUTE)
                   && (i_req.wdata == `LIFC_EXEC_RUN);

    // Execute word keeps the last value written, it does not self-clear
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            exec_q <= `LIFC_EXEC_NONE;
        end
        else if (write_to(i_req, `LIFC_ADDR_EXECUTE))
        begin
            exec_q <= i_req.wdata;
        end
    end

    // Password words are stored as written and only compared at execute
    // Left word: first two characters
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pass_left_q <= `LIFC_WORD_RESET;
        end
        else if (write_to(i_req, `LIFC_ADDR_PASS_LEFT))
        begin
            pass_left_q <= i_req.wdata;
        end
    end

    // Right word: last two characters
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pass_right_q <= `LIFC_WORD_RESET;
        end
        else if (write_to(i_req, `LIFC_ADDR_PASS_RIGHT))
        begin
            pass_right_q <= i_req.wdata;
        end
    end

    // Change-select words: a 1 puts the input under this command
    // Halves are written freely; nothing reaches the points until execute
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            select_q <= '0;
        end
        else
        begin
            if (write_to(i_req, `LIFC_ADDR_SEL_UPPER))
            begin
                select_q[31:16] <= i_req.wdata;
            end
            if (write_to(i_req, `LIFC_ADDR_SEL_LOWER))
            begin
                select_q[15:0] <= i_req.wdata;
            end
        end
    end

    // Mode words: a 1 is force mode, a 0 normal mode
    // Same bit mapping as the change-select words
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_q <= '0;
        end
        else
        begin
            if (write_to(i_req, `LIFC_ADDR_MODE_UPPER))
            begin
                mode_q[31:16] <= i_req.wdata;
            end
            if (write_to(i_req, `LIFC_ADDR_MODE_LOWER))
            begin
                mode_q[15:0] <= i_req.wdata;
            end
        end
    end

    // Forced-state words: a 1 forces on, a 0 forces off
    // Only meaningful where the point is selected and in force mode
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            value_q <= '0;
        end
        else
        begin
            if (write_to(i_req, `LIFC_ADDR_VAL_UPPER))
            begin
                value_q[31:16] <= i_req.wdata;
            end
            if (write_to(i_req, `LIFC_ADDR_VAL_LOWER))
            begin
                value_q[15:0] <= i_req.wdata;
            end
        end
    end

    // Applied masks change only on an authorised execute, so a half-written
    // set of masks never reaches the protection logic
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            active_q <= '0;
        end
        else if (exec_hit && pass_ok)
        begin
            active_q <= staged;
        end
    end

    // A refused execute stands flagged until the next execute of 1
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rejected_q <= 1'b0;
        end
        else if (exec_hit)
        begin
            rejected_q <= !pass_ok;
        end
    end

    // Point outputs are registered so that they never glitch mid-cycle

    // Forced flags follow the applied masks one edge after execute
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_point_forced <= '0;
        end
        else
        begin
            o_point_forced <= force_mask(active_q);
        end
    end

    // Point values: forced-on reports 1, forced-off 0, others pass through
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_point_value <= '0;
        end
        else
        begin
            o_point_value <= point_result(active_q, i_point_normal);
        end
    end

    // Summary of forcing, for a status indication
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_any_forced <= 1'b0;
        end
        else
        begin
            o_any_forced <= |force_mask(active_q);
        end
    end

    assign o_exec_rejected = rejected_q;

    // Read-back of staged words; the spare word reads as zero
    // Limitation: the host sees what is staged, not what is in force
    always_comb
    begin
        rdata_d = 16'h0000;
        unique case (i_req.addr)
            `LIFC_ADDR_EXECUTE:    rdata_d = exec_q;
            `LIFC_ADDR_PASS_LEFT:  rdata_d = pass_left_q;
            `LIFC_ADDR_PASS_RIGHT: rdata_d = pass_right_q;
            `LIFC_ADDR_SEL_UPPER:  rdata_d = upper_word(select_q);
            `LIFC_ADDR_SEL_LOWER:  rdata_d = lower_word(select_q);
            `LIFC_ADDR_MODE_UPPER: rdata_d = upper_word(mode_q);
            `LIFC_ADDR_MODE_LOWER: rdata_d = lower_word(mode_q);
            `LIFC_ADDR_VAL_UPPER:  rdata_d = upper_word(value_q);
            `LIFC_ADDR_VAL_LOWER:  rdata_d = lower_word(value_q);
            default:               rdata_d = 16'h0000;
        endcase
    end

    // Answer one edge after the access; read data stands only with its ack
    // Unmapped words get an error answer and have no effect
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rsp <= '0;
        end
        else
        begin
            o_rsp.ack   <= access && mapped;
            o_rsp.err   <= access && !mapped;
            o_rsp.rdata <= (i_req.rd && mapped) ? rdata_d : 16'h0000;
        end
    end

endmodule
`default_nettype wire

// File: logic/lifc_pkg.sv
/*
 Types of the logical input force control bank. Assumes lifc_cfg.svh
 carries the numbers.
*/
`default_nettype none
package lifc_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } lifc_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } lifc_rsp_t;

    typedef struct packed {
        logic [31:0] select;
        logic [31:0] mode;
        logic [31:0] value;
    } lifc_masks_t;

endpackage
`default_nettype wire

// File: test/lifc_force_bank_assertions.sv
/* Port checker for lifc_force_bank.
 Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
`include "lifc_cfg.svh"
module lifc_force_bank_chk #(
    parameter int unsigned POINTS = 32
)
(
    // All bank ports, watched only
    input wire logic                i_clock,
    input wire logic                i_rst_n,
    input wire lifc_pkg::lifc_req_t i_req,
    input wire lifc_pkg::lifc_rsp_t o_rsp,
    input wire logic [POINTS-1:0]   i_point_normal,
    input wire logic [POINTS-1:0]   o_point_value,
    input wire logic [POINTS-1:0]   o_point_forced,
    input wire logic                o_any_forced,
    input wire logic                o_exec_rejected
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic acc = i_req.wr | i_req.rd;
    wire logic hit = i_req.addr >= `LIFC_ADDR_EXECUTE && i_req.addr <= `LIFC_ADDR_VAL_LOWER;
    wire logic go  = i_req.wr && i_req.addr == `LIFC_ADDR_EXECUTE && i_req.wdata == `LIFC_EXEC_RUN;
    ack_hit_a: assert property (acc && hit |=> o_rsp.ack && !o_rsp.err)
        else $error("mapped access not acknowledged");
    err_miss_a: assert property (acc && !hit |=> o_rsp.err && !o_rsp.ack)
        else $error("unmapped access not refused");
    resp_cause_a: assert property ((o_rsp.ack || o_rsp.err) |-> $past(acc))
        else $error("response without access");
    rdata_idle_a: assert property (!o_rsp.ack |-> o_rsp.rdata == 16'h0000)
        else $error("read data outside an answer");
    unforced_pass_a: assert property ($past(i_rst_n) |->
        (o_point_value & ~o_point_forced) == ($past(i_point_normal) & ~o_point_forced))
        else $error("unforced point differs from input");
    any_forced_a: assert property (o_any_forced == |o_point_forced)
        else $error("summary flag wrong");
    forced_hold_a: assert property ($changed(o_point_forced) |-> $past(go, 2))
        else $error("forcing changed without execute");
    reject_hold_a: assert property ($changed(o_exec_rejected) |-> $past(go, 1))
        else $error("reject flag changed without execute");
    cover property (go);
    cover property (o_any_forced);
    cover property (o_exec_rejected);
endmodule
bind lifc_force_bank lifc_force_bank_chk #(.POINTS(POINTS)) chk (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_req(i_req), .o_rsp(o_rsp), .i_point_normal(i_point_normal),
    .o_point_value(o_point_value), .o_point_forced(o_point_forced),
    .o_any_forced(o_any_forced), .o_exec_rejected(o_exec_rejected));
`default_nettype wire

// File: test/lifc_force_bank_tb.sv
/* Self-checking bench for lifc_force_bank.
 Assumes lifc_host drives the register port. */
`timescale 1ns/100ps
`default_nettype none
`include "lifc_cfg.svh"
module lifc_force_bank_tb;
    logic                i_clock = 1'b0;
    logic                i_rst_n = 1'b0;
    logic [31:0]         normal  = 32'h1234_5678;
    lifc_pkg::lifc_req_t req;
    lifc_pkg::lifc_rsp_t rsp, r;
    logic [31:0]         val, frc, as = '0, am = '0, av = '0;
    logic                any, rej;
    int                  errors = 0;
    int                  n_compared = 0;
    always #20 i_clock = ~i_clock;
    lifc_force_bank #(.POINTS(32)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req),
        .o_rsp(rsp), .i_point_normal(normal), .o_point_value(val), .o_point_forced(frc),
        .o_any_forced(any), .o_exec_rejected(rej));
    lifc_host host (.i_clock(i_clock), .o_req(req), .i_rsp(rsp));
    task chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, d);
        host.xfer(1'b1, a, d, r);
    endtask
    task t_regs;
        for (int a = 16'hA0D5; a <= 16'hA0E0; a++)
        begin
            wr(a[15:0], 16'h5A00 + a[15:0]);
            chk({r.ack, r.err}, (a < 16'hA0D6 || a > 16'hA0DF) ? 1 : 2);
            host.xfer(1'b0, a[15:0], 16'h0000, r);
            chk(r.rdata, (a < 16'hA0D6 || a > 16'hA0D8 && a < 16'hA0DA || a > 16'hA0DF)
                ? 0 : 16'h5A00 + a[15:0]);
        end
        $display("register map test done");
    endtask
    // Bad password must leave the previous forcing in place
    task automatic t_force(input logic [15:0] pl, pr,
        input logic [31:0] s, m, v, input logic bad);
        logic [15:0] w [6];
        w = '{s[31:16], s[15:0], m[31:16], m[15:0], v[31:16], v[15:0]};
        for (int i = 0; i < 6; i++)
            wr(16'hA0DA + i[15:0], w[i]);
        host.login(pl, pr);
        wr(`LIFC_ADDR_EXECUTE, `LIFC_EXEC_NONE);
        @(posedge i_clock);
        chk(frc, as & am);
        as = bad ? as : s;
        am = bad ? am : m;
        av = bad ? av : v;
        normal <= ~normal;
        wr(`LIFC_ADDR_EXECUTE, `LIFC_EXEC_RUN);
        @(posedge i_clock);
        #1;
        chk(frc, as & am);
        chk(val, (as & am & av) | (~(as & am) & normal));
        chk(any, |(as & am));
        chk(rej, bad);
        $display("force test done");
    endtask
    initial
    begin
        repeat (12) @(posedge i_clock);
        chk(frc | val, 32'h0000_0000);
        i_rst_n <= 1'b1;
        t_regs;
        t_force(`LIFC_PASSWORD_LEFT, `LIFC_PASSWORD_RIGHT,
            32'hEE00_EEEE, 32'hCC00_CCCC, 32'hBB00_BBBB, 1'b0);
        t_force(16'h4142, `LIFC_PASSWORD_RIGHT,
            32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
        t_force(`LIFC_PASSWORD_LEFT, 16'h4241,
            32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b1);
        t_force(`LIFC_PASSWORD_LEFT, `LIFC_PASSWORD_RIGHT,
            32'h0001_8000, 32'hFFFF_FFFF, 32'h0000_8000, 1'b0);
        report_and_stop;
    end
    // Whole run is a few hundred cycles; 100 us leaves ample margin
    initial
    begin
        #100us;
        errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire

// File: test/lifc_host.sv
/* Remote host model for the register bank.
 Assumes the answer stands in the cycle after the taking edge. */
`timescale 1ns/100ps
`default_nettype none
module lifc_host
(
    input  wire logic                i_clock,
    output var lifc_pkg::lifc_req_t  o_req,
    input  wire lifc_pkg::lifc_rsp_t i_rsp
);
    initial o_req = '0;
    // Strobe held one cycle only, so no access is taken twice
    task automatic xfer(input logic w, input logic [15:0] a, d, output lifc_pkg::lifc_rsp_t r);
        @(posedge i_clock);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clock);
        o_req <= '0;
        @(posedge i_clock);
        r = i_rsp;
    endtask
    task automatic login(input logic [15:0] lp, rp);
        lifc_pkg::lifc_rsp_t r;
        xfer(1'b1, 16'hA0D7, lp, r);
        xfer(1'b1, 16'hA0D8, rp, r);
    endtask
endmodule
`default_nettype wire
